// file: pkg/cmpl_pkg.sv
package cmpl_pkg;
  // page identity and size
  localparam logic [5:0] PAGE_CODE = 6'h0a;
  localparam logic [7:0] PAGE_LEN = 8'h0a;
  localparam logic SAVABLE = 1'h1;
  // byte offsets inside the page
  localparam logic [3:0] OFF_HEADER = 4'h0;
  localparam logic [3:0] OFF_LENGTH = 4'h1;
  localparam logic [3:0] OFF_FIRST_RW = 4'h2;
  localparam logic [3:0] OFF_LAST_RW = 4'h9;
  localparam logic [3:0] OFF_STEST_HI = 4'ha;
  localparam logic [3:0] OFF_STEST_LO = 4'hb;
  // field positions, byte index relative to OFF_FIRST_RW
  localparam int TSK_BYTE = 0;
  localparam int TSK_LSB = 5;
  localparam int LAD_BIT = 1;
  localparam int LER_BIT = 0;
  localparam int QUE_BYTE = 1;
  localparam int QAM_LSB = 4;
  localparam int QEA_BIT = 1;
  localparam int QTD_BIT = 0;
  localparam int EVT_BYTE = 2;
  localparam int SWL_BIT = 3;
  localparam int BUSY_LO_BYTE = 7;
  localparam int BUSY_HI_BYTE = 6;
  // writable bits per byte (bytes 9 down to 2) and reset contents
  localparam logic [63:0] PAGE_CHG = 64'hffff_ffff_000f_f7e3;
  localparam logic [63:0] PAGE_RST = 64'h0000_0000_0000_0000;
  // field encodings
  localparam logic [2:0] TSK_SHARED = 3'h0;
  localparam logic [2:0] TSK_PER_INIT = 3'h1;
  localparam logic [3:0] QAM_STRICT = 4'h0;
  localparam logic [3:0] QAM_FREE = 4'h1;
  localparam logic [3:0] QAM_VENDOR = 4'h8;
  localparam logic [15:0] BUSY_UNLIMITED = 16'hffff;
  // self-test time in seconds, value arbitrary
  localparam logic [15:0] STEST_SECS = 16'h0000;
  // sense codes
  localparam logic [3:0] SK_DATA_PROTECT = 4'h7;
  localparam logic [7:0] ASC_WRITE_PROT = 8'h27;
  localparam logic [7:0] ASC_MODE_CHANGED = 8'h2a;
  localparam logic [7:0] ASC_CMDS_CLEARED = 8'h2f;
  localparam int NUM_INIT = 16;
  typedef enum logic [1:0] {WL_OPEN, WL_FLUSH, WL_LOCKED} cmpl_lock_type;
endpackage

// file: hw/cmpl_control_page.sv
// Summary of operation
// - header byte holds page code, savable top
// - savable flag reads one
// - task set kind 000 shared, 001 per-initiator
// - one shared copy seen by all initiators
// - kind change posts attention to others
// - log autosave disable bit steers saving
// - log exception report bit gates reporting
// - reorder policy limits simple-tag reordering
// - policy zero keeps strict ordering
// - policy one allows free reordering
// - queue error abort aborts and posts attention
// - tagging disable aborts pending tagged work
// - soft write lock flushes, refusing writes from flush start
// - busy timeout FFFFh means unlimited
`timescale 1ns/1ps
`default_nettype none
module cmpl_control_page
  import cmpl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode select: open, byte writes, commit
  input wire logic selStart,
  input wire logic selValid,
  input wire logic [3:0] selByte,
  input wire logic [7:0] selData,
  input wire logic selCommit,
  input wire logic [3:0] selInitiator,
  output logic selDone,
  output logic selReject,
  // mode sense
  input wire logic senseReq,
  input wire logic [3:0] senseByte,
  output logic senseValid,
  output logic [7:0] senseData,
  // unit attention per initiator
  input wire logic [NUM_INIT-1:0] uaClear,
  output logic [NUM_INIT-1:0] uaPending,
  output logic [7:0] uaAsc,
  // queue events
  input wire logic allegianceEnd,
  input wire logic [3:0] allegianceInitiator,
  input wire logic [NUM_INIT-1:0] queuedMask,
  output logic abortQueued,
  output logic tagAbort,
  // medium write guard
  input wire logic mediumWriteReq,
  input wire logic flushDone,
  output logic flushReq,
  output logic writeRefuse,
  output logic [3:0] refuseSenseKey,
  output logic [7:0] refuseAsc,
  // decoded controls
  output logic [2:0] taskSetKind,
  output logic logAutosaveDisable,
  output logic logExceptionReport,
  output logic reorderFree,
  output logic queueErrorAbort,
  output logic queueTaggingDisable,
  output logic softWriteLock,
  output logic busyUnlimited
);

  //--------------------------------------------------------------
  // page storage and mode select
  //--------------------------------------------------------------
  logic [7:0][7:0] page, stage, next_page, next_stage;
  logic next_selDone, next_selReject, next_abortQueued, next_tagAbort;
  logic [NUM_INIT-1:0] next_uaPending, uaSet;
  logic [7:0] next_uaAsc;
  logic next_busyUnlimited;
  logic [2:0] stTsk;
  logic [3:0] stQam;
  logic [2:0] wIdx;
  logic [7:0] wMask;

  assign wIdx = 3'(selByte - OFF_FIRST_RW);
  assign wMask = PAGE_CHG[8*wIdx +: 8];
  assign stTsk = stage[TSK_BYTE][TSK_LSB +: 3];
  assign stQam = stage[QUE_BYTE][QAM_LSB +: 4];

  always_comb begin
    next_stage = stage;
    next_page = page;
    next_selDone = 1'h0;
    next_selReject = 1'h0;
    next_abortQueued = 1'h0;
    next_tagAbort = 1'h0;
    next_uaAsc = uaAsc;
    uaSet = '0;
    if (selStart) begin
      next_stage = page;
    end else if (selValid && selByte >= OFF_FIRST_RW &&
                 selByte <= OFF_LAST_RW) begin
      // only changeable bits take the written value
      next_stage[wIdx] = (stage[wIdx] & ~wMask) | (selData & wMask);
    end
    if (selCommit) begin
      // reserved kind or policy: page left untouched
      if (stTsk > TSK_PER_INIT ||
          (stQam > QAM_FREE && stQam < QAM_VENDOR)) begin
        next_selReject = 1'h1;
      end else begin
        next_page = stage;
        next_selDone = 1'h1;
        if (stTsk != page[TSK_BYTE][TSK_LSB +: 3]) begin
          uaSet = ~(NUM_INIT'(1) << selInitiator);
          next_uaAsc = ASC_MODE_CHANGED;
        end
        // a fresh disable drops whatever tagged work is pending
        next_tagAbort = stage[QUE_BYTE][QTD_BIT] &
                        ~page[QUE_BYTE][QTD_BIT];
      end
    end
    if (allegianceEnd && page[QUE_BYTE][QEA_BIT]) begin
      next_abortQueued = 1'h1;
      uaSet = uaSet | (queuedMask &
              ~(NUM_INIT'(1) << allegianceInitiator));
      next_uaAsc = ASC_CMDS_CLEARED;
    end
    // a new attention wins over a clear in the same cycle
    next_uaPending = (uaPending & ~uaClear) | uaSet;
    next_busyUnlimited = {next_page[BUSY_HI_BYTE],
                          next_page[BUSY_LO_BYTE]} == BUSY_UNLIMITED;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page <= PAGE_RST;
      stage <= PAGE_RST;
      selDone <= 1'h0;
      selReject <= 1'h0;
      uaPending <= '0;
      uaAsc <= 8'h00;
      busyUnlimited <= 1'h0;
      abortQueued <= 1'h0;
      tagAbort <= 1'h0;
    end else begin
      page <= next_page;
      stage <= next_stage;
      selDone <= next_selDone;
      selReject <= next_selReject;
      uaPending <= next_uaPending;
      uaAsc <= next_uaAsc;
      busyUnlimited <= next_busyUnlimited;
      abortQueued <= next_abortQueued;
      tagAbort <= next_tagAbort;
    end
  end

  // controls other than reorderFree and busyUnlimited are plain bit selects of the page flops
  assign taskSetKind = page[TSK_BYTE][TSK_LSB +: 3];
  assign logAutosaveDisable = page[TSK_BYTE][LAD_BIT];
  assign logExceptionReport = page[TSK_BYTE][LER_BIT];
  // strict ordering unless policy one; vendor codes stay strict
  assign reorderFree = page[QUE_BYTE][QAM_LSB +: 4] == QAM_FREE;
  assign queueErrorAbort = page[QUE_BYTE][QEA_BIT];
  assign queueTaggingDisable = page[QUE_BYTE][QTD_BIT];
  assign softWriteLock = page[EVT_BYTE][SWL_BIT];

  //--------------------------------------------------------------
  // medium write guard
  //--------------------------------------------------------------
  cmpl_lock_type lockState, next_lockState;
  logic next_flushReq, next_writeRefuse;
  logic [3:0] next_refuseSenseKey;
  logic [7:0] next_refuseAsc;

  always_comb begin
    next_lockState = lockState;
    next_refuseSenseKey = refuseSenseKey;
    next_refuseAsc = refuseAsc;
    unique case (lockState)
      WL_OPEN: if (softWriteLock) next_lockState = WL_FLUSH;
      WL_FLUSH: begin
        if (!softWriteLock) next_lockState = WL_OPEN;
        else if (flushDone) next_lockState = WL_LOCKED;
      end
      WL_LOCKED: if (!softWriteLock) next_lockState = WL_OPEN;
      default: next_lockState = WL_OPEN;
    endcase
    next_flushReq = next_lockState == WL_FLUSH;
    // new writes are refused already while the cache drains,
    // so nothing lands behind the flush
    next_writeRefuse = mediumWriteReq && lockState != WL_OPEN;
    if (next_writeRefuse) begin
      next_refuseSenseKey = SK_DATA_PROTECT;
      next_refuseAsc = ASC_WRITE_PROT;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockState <= WL_OPEN;
      flushReq <= 1'h0;
      writeRefuse <= 1'h0;
      refuseSenseKey <= 4'h0;
      refuseAsc <= 8'h00;
    end else begin
      lockState <= next_lockState;
      flushReq <= next_flushReq;
      writeRefuse <= next_writeRefuse;
      refuseSenseKey <= next_refuseSenseKey;
      refuseAsc <= next_refuseAsc;
    end
  end

  //--------------------------------------------------------------
  // mode sense
  //--------------------------------------------------------------
  logic [7:0] next_senseData;
  logic [2:0] rIdx;
  assign rIdx = 3'(senseByte - OFF_FIRST_RW);

  always_comb begin
    if (senseByte == OFF_HEADER) begin
      next_senseData = {SAVABLE, 1'h0, PAGE_CODE};
    end else if (senseByte == OFF_LENGTH) begin
      next_senseData = PAGE_LEN;
    end else if (senseByte <= OFF_LAST_RW) begin
      next_senseData = page[rIdx];
    end else if (senseByte == OFF_STEST_HI) begin
      next_senseData = STEST_SECS[15:8];
    end else if (senseByte == OFF_STEST_LO) begin
      next_senseData = STEST_SECS[7:0];
    end else begin
      next_senseData = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      senseValid <= 1'h0;
      senseData <= 8'h00;
    end else begin
      senseValid <= senseReq;
      senseData <= senseReq ? next_senseData : senseData;
    end
  end

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  header_read_a: assert property (
    senseReq && senseByte == OFF_HEADER |=> senseValid &&
      senseData == {SAVABLE, 1'h0, PAGE_CODE})
    else $error("header byte wrong");
  kind_attention_a: assert property (
    selCommit && !next_selReject && !allegianceEnd &&
      stTsk != taskSetKind |=> uaAsc == ASC_MODE_CHANGED &&
      (uaPending | (NUM_INIT'(1) << $past(selInitiator))) == '1 &&
      uaPending[$past(selInitiator)] == $past(uaPending[selInitiator]
      & ~uaClear[selInitiator]))
    else $error("attention sent to issuer or missing");
  reject_keep_a: assert property (
    selCommit && stTsk > TSK_PER_INIT |=> selReject && $stable(page))
    else $error("reserved kind accepted");
  shared_copy_a: assert property (
    selCommit && !next_selReject |=> page == $past(stage) && selDone)
    else $error("commit did not update page");
  queue_error_abort_abort_a: assert property (
    allegianceEnd && queueErrorAbort |=> abortQueued)
    else $error("queued commands not aborted");
  tag_abort_a: assert property (
    tagAbort |-> queueTaggingDisable && !$past(queueTaggingDisable))
    else $error("tag abort without fresh disable");
  lock_flush_a: assert property (
    $rose(softWriteLock) |=> flushReq)
    else $error("no flush on write lock");
  write_refuse_a: assert property (
    mediumWriteReq && lockState == WL_LOCKED |=> writeRefuse &&
      refuseSenseKey == SK_DATA_PROTECT && refuseAsc == ASC_WRITE_PROT)
    else $error("write not refused");
  no_refuse_a: assert property (
    !softWriteLock && lockState == WL_OPEN |=> !writeRefuse)
    else $error("write refused while open");
  ua_set_wins_a: assert property (
    uaSet[0] && uaClear[0] |=> uaPending[0])
    else $error("clear beat new attention");

  select_ok_c: cover property (selStart ##[1:8] selCommit ##1 selDone);
  kind_change_c: cover property (selDone && uaAsc == ASC_MODE_CHANGED);
  locked_c: cover property (lockState == WL_LOCKED ##1 writeRefuse);
  reject_c: cover property (selReject);

endmodule
`default_nettype wire

// file: verification/cmpl_init_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// initiator side: mode select and mode sense requests
// ----------------
module cmpl_init_model (
  // clock
  input wire logic clk,
  // select
  output logic selStart,
  output logic selValid,
  output logic [3:0] selByte,
  output logic [7:0] selData,
  output logic selCommit,
  output logic [3:0] selInitiator,
  input wire logic selDone,
  input wire logic selReject,
  // sense
  output logic senseReq,
  output logic [3:0] senseByte,
  input wire logic senseValid,
  input wire logic [7:0] senseData
);
  initial begin
    selStart = 1'h0;
    selValid = 1'h0;
    selByte = 4'h0;
    selData = 8'h00;
    selCommit = 1'h0;
    selInitiator = 4'h0;
    senseReq = 1'h0;
    senseByte = 4'h0;
  end

  // two byte writes then commit; ans is {done, reject}
  task automatic sel(input logic [3:0] b0, input logic [7:0] d0,
      input logic [3:0] b1, input logic [7:0] d1, input logic [3:0] id,
      output logic [1:0] ans);
    @(posedge clk);
    selStart <= 1'h1;
    @(posedge clk);
    selStart <= 1'h0;
    selValid <= 1'h1;
    selByte <= b0;
    selData <= d0;
    @(posedge clk);
    selByte <= b1;
    selData <= d1;
    @(posedge clk);
    selValid <= 1'h0;
    // released data line must not keep its last value
    selData <= ~d1;
    selCommit <= 1'h1;
    selInitiator <= id;
    @(posedge clk);
    selCommit <= 1'h0;
    #1 ans = {selDone, selReject};
  endtask

  // one byte read; res is {valid, data}
  task automatic sense(input logic [3:0] b, output logic [8:0] res);
    @(posedge clk);
    senseReq <= 1'h1;
    senseByte <= b;
    @(posedge clk);
    senseReq <= 1'h0;
    #1 res = {senseValid, senseData};
  endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cmpl_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0;
  logic selStart, selValid, selCommit, selDone, selReject;
  logic senseReq, senseValid, allegianceEnd = 1'h0, abortQueued, tagAbort;
  logic [3:0] selByte, selInitiator, senseByte, refuseSenseKey;
  logic [3:0] allegianceInitiator = 4'h0;
  logic [7:0] selData, senseData, uaAsc, refuseAsc;
  logic [15:0] uaClear = 16'h0000, queuedMask = 16'h0000, uaPending;
  logic mediumWriteReq = 1'h0, flushDone = 1'h0, flushReq, writeRefuse;
  logic [2:0] taskSetKind;
  logic logAutosaveDisable, logExceptionReport, reorderFree;
  logic queueErrorAbort, queueTaggingDisable, softWriteLock, busyUnlimited;
  logic sawTag = 1'h0;
  logic [1:0] ans;
  logic [8:0] res;
  int mismatches = 0, comparisons = 0, cycles = 0;
  logic [3:0] rowByte [5] = '{4'h0, 4'h1, 4'h2, 4'ha, 4'hd};
  logic [7:0] rowExp [5] = '{8'h8a, 8'h0a, 8'h00, 8'h00, 8'h00};

  always #2 clk = ~clk;

  cmpl_init_model pm (.clk(clk), .selStart(selStart), .selValid(selValid),
    .selByte(selByte), .selData(selData), .selCommit(selCommit),
    .selInitiator(selInitiator), .selDone(selDone), .selReject(selReject),
    .senseReq(senseReq), .senseByte(senseByte), .senseValid(senseValid),
    .senseData(senseData));

  cmpl_control_page uut (.clk(clk), .rst_n(rst_n), .selStart(selStart),
    .selValid(selValid), .selByte(selByte), .selData(selData),
    .selCommit(selCommit), .selInitiator(selInitiator), .selDone(selDone),
    .selReject(selReject), .senseReq(senseReq), .senseByte(senseByte),
    .senseValid(senseValid), .senseData(senseData), .uaClear(uaClear),
    .uaPending(uaPending), .uaAsc(uaAsc), .allegianceEnd(allegianceEnd),
    .allegianceInitiator(allegianceInitiator), .queuedMask(queuedMask),
    .abortQueued(abortQueued), .tagAbort(tagAbort),
    .mediumWriteReq(mediumWriteReq), .flushDone(flushDone),
    .flushReq(flushReq), .writeRefuse(writeRefuse),
    .refuseSenseKey(refuseSenseKey), .refuseAsc(refuseAsc),
    .taskSetKind(taskSetKind), .logAutosaveDisable(logAutosaveDisable),
    .logExceptionReport(logExceptionReport), .reorderFree(reorderFree),
    .queueErrorAbort(queueErrorAbort),
    .queueTaggingDisable(queueTaggingDisable),
    .softWriteLock(softWriteLock), .busyUnlimited(busyUnlimited));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) allegianceEnd <= 1'h1;
    else if (which == 1) mediumWriteReq <= 1'h1;
    else if (which == 2) flushDone <= 1'h1;
    else uaClear <= 16'hffff;
    @(posedge clk);
    allegianceEnd <= 1'h0;
    mediumWriteReq <= 1'h0;
    flushDone <= 1'h0;
    uaClear <= 16'h0000;
    #1;
  endtask

  // the tagging abort pulse comes with the commit answer and is gone by the check
  always @(posedge clk) begin
    if (tagAbort === 1'h1) sawTag <= 1'h1;
  end

  // a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      pm.sense(rowByte[i], res);
      chk(res, {1'h1, rowExp[i]});
    end
    // a clear of every initiator lands on the commit edge: set must win
    fork
      pm.sel(4'h2, 8'h20, 4'h2, 8'h20, 4'h3, ans);
      begin
        repeat (4) @(posedge clk);
        uaClear <= 16'hffff;
        @(posedge clk);
        uaClear <= 16'h0000;
      end
    join
    chk(ans, 2'h2);
    chk(taskSetKind, TSK_PER_INIT);
    chk(uaPending, 16'hfff7);
    chk(uaAsc, 8'h2a);
    pm.sense(4'h2, res);
    chk(res, 9'h120);
    pulse(3);
    pm.sel(4'h2, 8'h43, 4'h2, 8'h43, 4'h1, ans);
    chk(ans, 2'h1);
    pm.sel(4'h3, 8'h20, 4'h3, 8'h20, 4'h1, ans);
    chk(ans, 2'h1);
    pm.sense(4'h2, res);
    chk(res, 9'h120);
    pm.sel(4'h2, 8'h23, 4'h2, 8'h23, 4'h1, ans);
    chk(ans, 2'h2);
    chk({logAutosaveDisable, logExceptionReport}, 2'h3);
    chk(uaPending, 16'h0000);
    pm.sel(4'h3, 8'h12, 4'h3, 8'h12, 4'h1, ans);
    chk({reorderFree, queueErrorAbort}, 2'h3);
    @(posedge clk);
    allegianceInitiator <= 4'h2;
    queuedMask <= 16'h0006;
    pulse(0);
    chk(abortQueued, 1'h1);
    chk(uaPending, 16'h0002);
    chk(uaAsc, 8'h2f);
    pm.sel(4'h3, 8'h01, 4'h3, 8'h01, 4'h1, ans);
    repeat (3) @(posedge clk);
    #1 chk({reorderFree, queueTaggingDisable, sawTag}, 3'h3);
    pulse(0);
    chk(abortQueued, 1'h0);
    pm.sel(4'h8, 8'hff, 4'h9, 8'hff, 4'h1, ans);
    chk(busyUnlimited, 1'h1);
    pm.sel(4'h8, 8'hff, 4'h9, 8'hfe, 4'h1, ans);
    chk(busyUnlimited, 1'h0);
    pulse(1);
    chk(writeRefuse, 1'h0);
    pm.sel(4'h4, 8'h08, 4'h4, 8'h08, 4'h1, ans);
    repeat (2) @(posedge clk);
    #1 chk({softWriteLock, flushReq}, 2'h3);
    pulse(2);
    @(posedge clk);
    #1 chk(flushReq, 1'h0);
    pulse(1);
    chk(writeRefuse, 1'h1);
    chk({refuseSenseKey, refuseAsc}, {SK_DATA_PROTECT, ASC_WRITE_PROT});
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    pm.sense(4'h2, res);
    chk(res, 9'h100);
    chk({uaPending, taskSetKind}, 19'h0);
    end_sim();
  end
endmodule
`default_nettype wire
